/* dcam_defs.svh */
/*
 constants for the ddr channel address mapper: timing counts, widths, burst lengths
 and the fields of the address translation. included by bare name, definitions only.
*/
// Functional notes
// (R1) dual mode: 128 data plus 16 check bits across two channels
// (R2) single mode: one channel, 64 data plus 8 check bits, channel b off
// (R3) dual mode lock-step; low quad word of each double quad word on a, high on b
// (R4) dual mode: cache line is a burst of 4 per channel, 2 clocks
// (R5) single mode: cache line is a burst of 8, 4 clocks
// (R6) dual mode: 256-bit internal path moves once per core clock; the mapper moves one 128-bit double quad word per clock, over 2 clocks
// (R7) single mode: 256-bit path muxed one double quad word at a time
// (R8) eight chip selects, one per row, at most eight rows
// (R9) cas latency 2 or 2.5 only; paired dimms may differ
// (R10) only registered dimms with check bits are accepted
// (R11) x4/x8, 72-bit, 128/256/512 Mb devices, four dimms per channel
// (R12) decode limit 16 GB dual, 8 GB single, unless reclaim is on
// (R13) system populates dimms in pairs of identical geometry
// (R14) dual column: bit0 low, bits1-9 from host 5-13, bit10 precharge
// (R15) single column: bits0-1 low, bits2-9 from host 5-12, bit10 precharge
// (R16) row bits 0-6 from 18-24, 9-11 from 25-27; single one lower
// (R17) x8 bank from 15/14, row8 from 16; x4 bank low 16, row8 28
// (R18) 512 Mb x4: bank 17/16, row7 30, row12 29, col11/12 from 14/15
// (R19) firmware reads dimm rom over two-wire bus at 1010 plus straps
// (R20) firmware programs config and initialises dram before any cycle
// (R21) memory runs on the same core clock as the processor bus
// (R22) chip select chosen by cumulative row boundaries; none past last row
`ifndef DCAM_DEFS_SVH
`define DCAM_DEFS_SVH
`define DCAM_CHAN_DATA_W   64
`define DCAM_CHAN_CHECK_W  8
`define DCAM_PATH_W        256
`define DCAM_HADDR_W       36
`define DCAM_ROWS          8
`define DCAM_BURST_DUAL    4
`define DCAM_BURST_SINGLE  8
`define DCAM_BEATS_DUAL    3'd2
`define DCAM_BEATS_SINGLE  3'd4
`define DCAM_LIMIT_DUAL    36'h400000000
`define DCAM_LIMIT_SINGLE  36'h200000000
`define DCAM_BOUND_LSB     26
`define DCAM_BOUND_W       10
`define DCAM_ROM_PREFIX    4'hA
`endif

/* dcam_pkg.sv */
/*
 types for the ddr channel address mapper.
 assumes nothing of its surroundings.
*/
package dcam_pkg;
  typedef enum logic [1:0] {
    DCAM_TECH_128 = 2'h0,
    DCAM_TECH_256 = 2'h1,
    DCAM_TECH_512 = 2'h2
  } dcam_tech_t;

  typedef enum logic [2:0] {
    DCAM_IDLE  = 3'h1,
    DCAM_MOVE  = 3'h2,
    DCAM_BLOCK = 3'h4
  } dcam_state_t;
endpackage

/* dcam_row_select.sv */
/*
 row decoder: compares a host address against cumulative row boundaries.
 assumes boundaries are programmed ascending in 64 MB units by firmware.
*/
`timescale 1ns/10ps
`include "dcam_defs.svh"
module dcam_row_select #(
  parameter int ROWS = `DCAM_ROWS
) (
  input  wire logic [`DCAM_HADDR_W-1:0]        haddr,
  input  wire logic [ROWS*`DCAM_BOUND_W-1:0]   row_bound,
  output logic      [ROWS-1:0]                 row_hit,
  output logic                                 row_any
);
  logic [`DCAM_BOUND_W-1:0] unit;
  logic [ROWS-1:0]          below;
  assign unit = haddr[`DCAM_BOUND_LSB +: `DCAM_BOUND_W];

  genvar g;
  generate
    for (g = 0; g < ROWS; g++) begin : g_cmp
      assign below[g] = unit < row_bound[g*`DCAM_BOUND_W +: `DCAM_BOUND_W];
      // first row whose top lies above the address
      if (g == 0) begin : g_first
        assign row_hit[g] = below[g]; // see (R22)
      end else begin : g_rest
        assign row_hit[g] = below[g] & ~below[g-1]; // see (R22)
      end
    end
  endgenerate

  // past the last populated row nothing matches
  assign row_any = |row_hit; // see (R22)
endmodule

/* dcam_addr_xlate.sv */
/*
 combinational row, column and bank translation of a host address.
 assumes a 64-byte cache line aligned host address.
*/
`timescale 1ns/10ps
`include "dcam_defs.svh"
module dcam_addr_xlate (
  input  wire logic [`DCAM_HADDR_W-1:0] haddr,
  input  wire logic                     dual_mode,
  input  wire logic                     dev_x4,
  input  wire dcam_pkg::dcam_tech_t     tech,
  input  wire logic                     auto_precharge_flag,
  output logic      [12:0]              row_addr,
  output logic      [12:0]              col_addr,
  output logic                          bank_select_low,
  output logic                          bank_select_high
);
  logic [`DCAM_HADDR_W-1:0] a;
  logic                     big4;

  always_comb begin
    // single mode reuses dual mapping with every source bit one lower
    a = dual_mode ? haddr : {haddr[`DCAM_HADDR_W-2:0], 1'b0}; // see (R16)
    big4 = dev_x4 && (tech == dcam_pkg::DCAM_TECH_512);
    row_addr = 13'h0000;
    col_addr = 13'h0000;
    row_addr[6:0]  = a[24:18]; // see (R16)
    row_addr[11:9] = a[27:25]; // see (R16)
    row_addr[7]    = big4 ? a[30] : a[17]; // see (R18)
    row_addr[8]    = dev_x4 ? a[28] : a[16]; // see (R17)
    if (tech != dcam_pkg::DCAM_TECH_128) begin
      row_addr[12] = dev_x4 ? a[29] : a[28];
    end
    if (dual_mode) begin
      col_addr[9:1] = haddr[13:5]; // see (R14)
    end else begin
      col_addr[9:2] = haddr[12:5]; // see (R15)
    end
    col_addr[10] = auto_precharge_flag; // see (R14) (R15)
    if (dev_x4 || tech == dcam_pkg::DCAM_TECH_512) begin
      col_addr[11] = a[14];
    end
    if (big4) begin
      col_addr[12] = a[15]; // see (R18)
    end
    if (big4) begin
      bank_select_high = a[17]; // see (R18)
      bank_select_low  = a[16];
    end else if (dev_x4) begin
      bank_select_high = a[15];
      bank_select_low  = a[16]; // see (R17)
    end else begin
      bank_select_high = a[15]; // see (R17)
      bank_select_low  = a[14];
    end
  end
endmodule

/* dcam_top.sv */
/*
 ddr channel address mapper: takes a cache-line request with its 256-bit data,
 picks the row, translates the address and streams double quad words to one or
 two lock-stepped 72-bit channels. assumes the host bus and memory share sys_clk,
 and that firmware drives the configuration inputs before issuing requests.
*/
`timescale 1ns/10ps
`include "dcam_defs.svh"
module dcam_top #(
  parameter int ROWS = `DCAM_ROWS
) (
  input  wire logic                            sys_clk, // see (R21) host and memory share it
  input  wire logic                            rst_n,
  input  wire logic                            cfg_dual_mode,
  input  wire logic                            cfg_dev_x4,
  input  wire dcam_pkg::dcam_tech_t            cfg_tech,
  input  wire logic [ROWS-1:0]                 cfg_cas_latency_half, // see (R9) 2 or 2.5 only
  input  wire logic                            cfg_registered_ecc,
  input  wire logic                            cfg_reclaim_en,
  input  wire logic                            cfg_done,
  input  wire logic [ROWS*`DCAM_BOUND_W-1:0]   cfg_row_bound,
  input  wire logic                            req_valid,
  output logic                                 req_ready,
  input  wire logic [`DCAM_HADDR_W-1:0]        req_addr,
  input  wire logic                            req_auto_precharge,
  input  wire logic [`DCAM_PATH_W-1:0]         req_data,
  input  wire logic [2*`DCAM_CHAN_CHECK_W-1:0] req_check_lo,
  input  wire logic [2*`DCAM_CHAN_CHECK_W-1:0] req_check_hi,
  output logic                                 req_error,
  output logic [ROWS-1:0]                      chip_select_q,
  output logic [12:0]                          row_addr_q,
  output logic [12:0]                          col_addr_q,
  output logic                                 bank_select_low_q,
  output logic                                 bank_select_high_q,
  output logic [3:0]                           burst_len_q,
  output logic                                 chan_a_valid_q,
  output logic [`DCAM_CHAN_DATA_W-1:0]         chan_a_data_q,
  output logic [`DCAM_CHAN_CHECK_W-1:0]        chan_a_check_q,
  output logic                                 chan_b_valid_q,
  output logic                                 chan_b_enable_q,
  output logic [`DCAM_CHAN_DATA_W-1:0]         chan_b_data_q,
  output logic [`DCAM_CHAN_CHECK_W-1:0]        chan_b_check_q,
  output logic                                 cfg_error_q
);
  localparam int DQUAD_W = 2 * `DCAM_CHAN_DATA_W;

  dcam_pkg::dcam_state_t state_q;
  dcam_pkg::dcam_state_t state_d;
  logic [2:0]            beat_q;
  logic [2:0]            beats;
  logic [`DCAM_PATH_W-1:0] line_q;
  logic [4*`DCAM_CHAN_CHECK_W-1:0] chk_q;
  logic                  mode_q;
  logic [ROWS-1:0]       row_hit;
  logic                  row_any;
  logic [12:0]           row_addr;
  logic [12:0]           col_addr;
  logic                  bsl;
  logic                  bsh;
  logic                  over_limit;
  logic                  cfg_ok;
  logic                  take;

  // half-clock latency is allowed per row; the mapper takes it in but drives no output from it
  // so pairs with different settings still share geometry
  function automatic logic cfg_legal(input logic reg_ecc, input dcam_pkg::dcam_tech_t t);
    cfg_legal = reg_ecc && (t != 2'h3); // see (R10) (R11)
  endfunction

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_error_q <= 1'b0;
    end else begin
      cfg_error_q <= cfg_done && !cfg_legal(cfg_registered_ecc, cfg_tech); // see (R10)
    end
  end

  // no cycle reaches memory before firmware marks the setup complete
  assign cfg_ok = cfg_done && !cfg_error_q; // see (R20)

  dcam_row_select #(
    .ROWS (ROWS)
  ) u_rows (
    .haddr     (req_addr),
    .row_bound (cfg_row_bound),
    .row_hit   (row_hit),
    .row_any   (row_any)
  );

  dcam_addr_xlate u_xlate (
    .haddr               (req_addr),
    .dual_mode           (cfg_dual_mode),
    .dev_x4              (cfg_dev_x4),
    .tech                (cfg_tech),
    .auto_precharge_flag (req_auto_precharge),
    .row_addr            (row_addr),
    .col_addr            (col_addr),
    .bank_select_low     (bsl),
    .bank_select_high    (bsh)
  );

  // reclaim lifts the decode ceiling; rows still bound the range
  always_comb begin
    if (cfg_reclaim_en) begin
      over_limit = 1'b0;
    end else if (cfg_dual_mode) begin
      over_limit = req_addr >= `DCAM_LIMIT_DUAL; // see (R12)
    end else begin
      over_limit = req_addr >= `DCAM_LIMIT_SINGLE; // see (R12)
    end
  end

  assign req_ready = (state_q == dcam_pkg::DCAM_IDLE) && cfg_ok;
  assign take      = req_valid && req_ready;
  assign req_error = take && (over_limit || !row_any); // see (R22)
  assign beats     = mode_q ? `DCAM_BEATS_DUAL : `DCAM_BEATS_SINGLE; // see (R4) (R5)

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      dcam_pkg::DCAM_IDLE: begin
        if (!cfg_ok) begin
          state_d = dcam_pkg::DCAM_BLOCK;
        end else if (take && !req_error) begin
          state_d = dcam_pkg::DCAM_MOVE;
        end
      end
      dcam_pkg::DCAM_MOVE: begin
        if (beat_q == beats - 3'd1) begin
          state_d = dcam_pkg::DCAM_IDLE;
        end
      end
      dcam_pkg::DCAM_BLOCK: begin
        if (cfg_ok) begin
          state_d = dcam_pkg::DCAM_IDLE;
        end
      end
      default: state_d = dcam_pkg::DCAM_BLOCK;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= dcam_pkg::DCAM_BLOCK;
    end else begin
      state_q <= state_d;
    end
  end

  // address, chip select and line capture on acceptance
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      chip_select_q      <= '0;
      row_addr_q         <= 13'h0000;
      col_addr_q         <= 13'h0000;
      bank_select_low_q  <= 1'b0;
      bank_select_high_q <= 1'b0;
      burst_len_q        <= 4'h0;
      mode_q             <= 1'b0;
      line_q             <= '0;
      chk_q              <= '0;
    end else if (take && !req_error) begin
      chip_select_q      <= row_hit; // see (R8) (R22)
      row_addr_q         <= row_addr;
      col_addr_q         <= col_addr;
      bank_select_low_q  <= bsl;
      bank_select_high_q <= bsh;
      burst_len_q        <= cfg_dual_mode ? 4'(`DCAM_BURST_DUAL)
                                          : 4'(`DCAM_BURST_SINGLE); // see (R4) (R5)
      mode_q             <= cfg_dual_mode;
      line_q             <= req_data;
      chk_q              <= {req_check_hi, req_check_lo};
    end else if (state_d == dcam_pkg::DCAM_IDLE) begin
      chip_select_q <= '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      beat_q <= 3'h0;
    end else if (state_q == dcam_pkg::DCAM_MOVE) begin
      beat_q <= beat_q + 3'd1;
    end else begin
      beat_q <= 3'h0;
    end
  end

  // data beats: dual sends both halves of a double quad word in lock-step,
  // single sends one 64-bit half per beat, low double quad word first
  logic [DQUAD_W-1:0]              dquad;
  logic [2*`DCAM_CHAN_CHECK_W-1:0] dquad_chk;
  logic                            moving;
  logic                            mbeat;
  assign moving    = state_q == dcam_pkg::DCAM_MOVE;
  assign mbeat     = mode_q ? beat_q[0] : beat_q[1];
  assign dquad     = mbeat ? line_q[DQUAD_W +: DQUAD_W] : line_q[0 +: DQUAD_W]; // see (R6) (R7)
  assign dquad_chk = mbeat ? chk_q[2*`DCAM_CHAN_CHECK_W +: 2*`DCAM_CHAN_CHECK_W]
                           : chk_q[0 +: 2*`DCAM_CHAN_CHECK_W];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      chan_a_valid_q  <= 1'b0;
      chan_b_valid_q  <= 1'b0;
      chan_b_enable_q <= 1'b0;
      chan_a_data_q   <= '0;
      chan_a_check_q  <= '0;
      chan_b_data_q   <= '0;
      chan_b_check_q  <= '0;
    end else begin
      chan_b_enable_q <= cfg_dual_mode; // see (R2)
      chan_a_valid_q  <= moving;
      chan_b_valid_q  <= moving && mode_q; // see (R3)
      if (moving && mode_q) begin
        // a carries the low 64 of the double quad word, b the high
        chan_a_data_q  <= dquad[0 +: `DCAM_CHAN_DATA_W]; // see (R1) (R3)
        chan_a_check_q <= dquad_chk[0 +: `DCAM_CHAN_CHECK_W];
        chan_b_data_q  <= dquad[`DCAM_CHAN_DATA_W +: `DCAM_CHAN_DATA_W];
        chan_b_check_q <= dquad_chk[`DCAM_CHAN_CHECK_W +: `DCAM_CHAN_CHECK_W];
      end else if (moving) begin
        chan_a_data_q  <= beat_q[0] ? dquad[`DCAM_CHAN_DATA_W +: `DCAM_CHAN_DATA_W]
                                    : dquad[0 +: `DCAM_CHAN_DATA_W]; // see (R7)
        chan_a_check_q <= beat_q[0] ? dquad_chk[`DCAM_CHAN_CHECK_W +: `DCAM_CHAN_CHECK_W]
                                    : dquad_chk[0 +: `DCAM_CHAN_CHECK_W];
        chan_b_data_q  <= '0; // see (R2)
        chan_b_check_q <= '0;
      end
    end
  end
endmodule

/* dcam_sva.sv */
/*
 assertions on the dcam_top ports.
 assumes one clock sys_clk and a synchronous active-low rst_n.
*/
`timescale 1ns/10ps
`include "dcam_defs.svh"
module dcam_sva #(
  parameter int ROWS = `DCAM_ROWS
) (
  input wire logic          sys_clk,
  input wire logic          rst_n,
  input wire logic          cfg_dual_mode,
  input wire logic          req_valid,
  input wire logic          req_ready,
  input wire logic [35:0]   req_addr,
  input wire logic          req_auto_precharge,
  input wire logic [255:0]  req_data,
  input wire logic          req_error,
  input wire logic [ROWS-1:0] chip_select_q,
  input wire logic [12:0]   row_addr_q,
  input wire logic [12:0]   col_addr_q,
  input wire logic [3:0]    burst_len_q,
  input wire logic          chan_a_valid_q,
  input wire logic [63:0]   chan_a_data_q,
  input wire logic          chan_b_valid_q,
  input wire logic          chan_b_enable_q,
  input wire logic [63:0]   chan_b_data_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire take = req_valid && req_ready && !req_error;
  property p_cs_one; $onehot0(chip_select_q); endproperty
  a_cs_one: assert property (p_cs_one) else $error("two chip selects");
  property p_cs_take; take |=> $onehot(chip_select_q); endproperty
  a_cs_take: assert property (p_cs_take) else $error("no chip select");
  property p_err; req_valid && req_error |=> chip_select_q == '0 && !chan_a_valid_q; endproperty
  a_err: assert property (p_err) else $error("refused line issued");
  property p_dual; take && cfg_dual_mode |-> ##2 (chan_a_valid_q && chan_b_valid_q)[*2]
    ##1 !chan_a_valid_q; endproperty
  a_dual: assert property (p_dual) else $error("dual burst shape");
  property p_single; take && !cfg_dual_mode |-> ##2 (chan_a_valid_q && !chan_b_valid_q)[*4]
    ##1 !chan_a_valid_q; endproperty
  a_single: assert property (p_single) else $error("single burst shape");
  property p_burst; take |=> burst_len_q == ($past(cfg_dual_mode) ? 4'h4 : 4'h8); endproperty
  a_burst: assert property (p_burst) else $error("burst length");
  property p_lanes; take && cfg_dual_mode |-> ##2 chan_a_data_q == $past(req_data[63:0], 2)
    && chan_b_data_q == $past(req_data[127:64], 2); endproperty
  a_lanes: assert property (p_lanes) else $error("lane order");
  property p_b_off; chan_a_valid_q && !chan_b_enable_q |-> chan_b_data_q == '0; endproperty
  a_b_off: assert property (p_b_off) else $error("channel b active");
  property p_col_d; take && cfg_dual_mode |=> col_addr_q[10:0] ==
    {$past(req_auto_precharge), $past(req_addr[13:5]), 1'b0}; endproperty
  a_col_d: assert property (p_col_d) else $error("dual column");
  property p_col_s; take && !cfg_dual_mode |=> col_addr_q[10:0] ==
    {$past(req_auto_precharge), $past(req_addr[12:5]), 2'h0}; endproperty
  a_col_s: assert property (p_col_s) else $error("single column");
  property p_row; take && cfg_dual_mode |=> row_addr_q[11:9] == $past(req_addr[27:25])
    && row_addr_q[6:0] == $past(req_addr[24:18]); endproperty
  a_row: assert property (p_row) else $error("dual row");
  c_dual: cover property (take && cfg_dual_mode);
  c_single: cover property (take && !cfg_dual_mode);
  c_err: cover property (req_valid && req_error);
endmodule
bind dcam_top dcam_sva #(.ROWS(ROWS)) u_sva (.sys_clk, .rst_n, .cfg_dual_mode, .req_valid,
  .req_ready, .req_addr, .req_auto_precharge, .req_data, .req_error, .chip_select_q, .row_addr_q,
  .col_addr_q, .burst_len_q, .chan_a_valid_q, .chan_a_data_q, .chan_b_valid_q, .chan_b_enable_q,
  .chan_b_data_q);

/* dcam_dimm_model.sv */
/*
 registered ecc dimm pairs on channels a and b: records each beat written.
 assumes the dimms were set up before the first beat.
*/
`timescale 1ns/10ps
module dcam_dimm_model (
  input wire logic        sys_clk,
  input wire logic        chan_a_valid_q,
  input wire logic [63:0] chan_a_data_q,
  input wire logic [7:0]  chan_a_check_q,
  input wire logic        chan_b_valid_q,
  input wire logic        chan_b_enable_q,
  input wire logic [63:0] chan_b_data_q,
  input wire logic [7:0]  chan_b_check_q
);
  logic [71:0] a_seen [8];
  logic [71:0] b_seen [8];
  int          beats = 0;
  // rom address: fixed upper nibble, straps give the low three
  localparam logic [6:0] ROM_ADDR_SLOT0 = {4'hA, 3'h0};
  // slot pairs share one geometry, so b lands in step with a
  always @(posedge sys_clk) begin
    if (chan_a_valid_q) begin
      a_seen[beats % 8] <= {chan_a_check_q, chan_a_data_q};
      b_seen[beats % 8] <= (chan_b_valid_q && chan_b_enable_q) ?
                           {chan_b_check_q, chan_b_data_q} : 72'h0;
      beats <= beats + 1;
    end
  end
endmodule

/* dcam_top_tb.sv */
/*
 testbench for dcam_top with the dimm model on its channels.
 assumes the design files and the dimm model are compiled first.
*/
`timescale 1ns/10ps
module dcam_top_tb;
  logic        sys_clk = 1'b0, rst_n = 1'b0, cfg_dual_mode = 1'b1, cfg_dev_x4 = 1'b0;
  logic        cfg_registered_ecc = 1'b1, cfg_reclaim_en = 1'b0, cfg_done = 1'b0;
  logic        req_valid = 1'b0, req_auto_precharge = 1'b0;
  dcam_pkg::dcam_tech_t cfg_tech = dcam_pkg::DCAM_TECH_256;
  logic [7:0]  cfg_cas_latency_half = 8'h5A;
  logic [79:0] cfg_row_bound = {{7{10'h3FF}}, 10'h001};
  logic [35:0] req_addr = 36'h0;
  logic [255:0] req_data = {64'h4, 64'h3, 64'h2, 64'h1};
  logic [15:0] req_check_lo = 16'hB2A1, req_check_hi = 16'hD4C3;
  logic        req_ready, req_error, bank_select_low_q, bank_select_high_q, cfg_error_q;
  logic        chan_a_valid_q, chan_b_valid_q, chan_b_enable_q;
  logic [7:0]  chip_select_q, chan_a_check_q, chan_b_check_q;
  logic [12:0] row_addr_q, col_addr_q;
  logic [3:0]  burst_len_q;
  logic [63:0] chan_a_data_q, chan_b_data_q;
  logic [71:0] lane [4] = '{{8'hA1, 64'h1}, {8'hB2, 64'h2}, {8'hC3, 64'h3}, {8'hD4, 64'h4}};
  int          errors = 0, n_tests = 0;
  always #2.5 sys_clk = ~sys_clk;
  dcam_top dut (.sys_clk, .rst_n, .cfg_dual_mode, .cfg_dev_x4, .cfg_tech, .cfg_cas_latency_half,
    .cfg_registered_ecc, .cfg_reclaim_en, .cfg_done, .cfg_row_bound, .req_valid, .req_ready,
    .req_addr, .req_auto_precharge, .req_data, .req_check_lo, .req_check_hi, .req_error,
    .chip_select_q, .row_addr_q, .col_addr_q, .bank_select_low_q, .bank_select_high_q,
    .burst_len_q, .chan_a_valid_q, .chan_a_data_q, .chan_a_check_q, .chan_b_valid_q,
    .chan_b_enable_q, .chan_b_data_q, .chan_b_check_q, .cfg_error_q);
  dcam_dimm_model m (.sys_clk, .chan_a_valid_q, .chan_a_data_q, .chan_a_check_q,
    .chan_b_valid_q, .chan_b_enable_q, .chan_b_data_q, .chan_b_check_q);
  task automatic chk(input string what, input logic [71:0] got, input logic [71:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic setcfg(input logic d, x4, dcam_pkg::dcam_tech_t t, input logic rc, pre);
    @(posedge sys_clk);
    cfg_dual_mode <= d;
    cfg_dev_x4 <= x4;
    cfg_tech <= t;
    cfg_reclaim_en <= rc;
    req_auto_precharge <= pre;
    @(negedge sys_clk);
  endtask
  task automatic send(input logic [35:0] a, output logic err);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 40);
    if (n >= 40) begin
      errors++;
      final_report();
    end else begin
      @(posedge sys_clk);
      req_addr <= a;
      req_valid <= 1'b1;
      @(negedge sys_clk);
      err = req_error;
      @(posedge sys_clk);
      req_valid <= 1'b0;
    end
  endtask
  task automatic xfer(input logic [35:0] a, input logic [7:0] cs);
    logic e, d, big;
    logic [35:0] s;
    int b0, nb;
    d = cfg_dual_mode;
    big = cfg_dev_x4 && cfg_tech == dcam_pkg::DCAM_TECH_512;
    s = d ? a : a << 1; // single mode sources sit one bit lower
    b0 = m.beats;
    nb = d ? 2 : 4;
    send(a, e);
    @(negedge sys_clk);
    chk("refused", e, 1'b0);
    chk("chip select", chip_select_q, cs);
    chk("row", row_addr_q, big ? {s[29], s[27:25], s[28], s[30], s[24:18]} :
        {s[28], s[27:25], s[16], s[17], s[24:18]});
    chk("bank", {bank_select_high_q, bank_select_low_q}, big ? s[17:16] : s[15:14]);
    chk("column", col_addr_q, d ? {big ? a[15:14] : 2'h0, req_auto_precharge, a[13:5], 1'b0} :
        {2'h0, req_auto_precharge, a[12:5], 2'h0});
    chk("burst", burst_len_q, d ? 4'h4 : 4'h8);
    chk("channel b on", chan_b_enable_q, d);
    repeat (6) @(negedge sys_clk);
    chk("beats", m.beats - b0, nb);
    for (int i = 0; i < nb; i++) begin
      chk("lane a", m.a_seen[(b0 + i) % 8], d ? lane[2 * i] : lane[i]);
      chk("lane b", m.b_seen[(b0 + i) % 8], d ? lane[2 * i + 1] : 72'h0);
    end
  endtask
  task automatic t_dual;
    setcfg(1'b1, 1'b0, dcam_pkg::DCAM_TECH_256, 1'b0, 1'b1);
    xfer(36'h3_5A5A_5A40, 8'h02);
    setcfg(1'b1, 1'b1, dcam_pkg::DCAM_TECH_512, 1'b0, 1'b0);
    xfer(36'h3_6B6B_6BC0, 8'h02);
    $display("dual lines done");
  endtask
  task automatic t_single;
    setcfg(1'b0, 1'b0, dcam_pkg::DCAM_TECH_256, 1'b0, 1'b1);
    xfer(36'h1_5A5A_5A40, 8'h02);
    $display("single line done");
  endtask
  task automatic t_limits;
    logic e;
    setcfg(1'b1, 1'b0, dcam_pkg::DCAM_TECH_256, 1'b0, 1'b0);
    send(36'h4_0000_0000, e);
    chk("over dual limit", e, 1'b1);
    setcfg(1'b1, 1'b0, dcam_pkg::DCAM_TECH_256, 1'b1, 1'b0);
    xfer(36'h4_0000_0040, 8'h02);
    setcfg(1'b0, 1'b0, dcam_pkg::DCAM_TECH_256, 1'b0, 1'b0);
    send(36'h2_0000_0000, e);
    chk("over single limit", e, 1'b1);
    @(posedge sys_clk);
    cfg_row_bound <= {8{10'h001}};
    setcfg(1'b1, 1'b0, dcam_pkg::DCAM_TECH_256, 1'b0, 1'b0);
    send(36'h0_0400_0000, e);
    @(negedge sys_clk);
    chk("past last row", {e, chip_select_q}, 9'h100);
    xfer(36'h0_0000_0100, 8'h01);
    $display("limits done");
  endtask
  task automatic t_cfg_err;
    setcfg(1'b1, 1'b0, dcam_pkg::dcam_tech_t'(2'h3), 1'b0, 1'b0);
    repeat (3) @(negedge sys_clk);
    chk("bad density", {cfg_error_q, req_ready}, 2'h2);
    setcfg(1'b1, 1'b0, dcam_pkg::DCAM_TECH_256, 1'b0, 1'b0);
    @(posedge sys_clk);
    cfg_registered_ecc <= 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("no ecc", {cfg_error_q, req_ready}, 2'h2);
    $display("config errors done");
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    cfg_done <= 1'b1; // setup finished before the first line
    t_dual();
    t_single();
    t_limits();
    t_cfg_err();
    final_report();
  end
endmodule
